//--- design/fifo_mb.sv
// dual-clock 36-bit fifo with mailboxes and port B bus matching
`timescale 1ns/1ns
`include "fifo_mb_regs.svh"
module fifo_mb
  import fifo_mb_pkg::*;
(
  // port A clock domain
  input  wire logic              CLOCK_IN,
  input  wire logic              RST_N_IN,
  // port B clock domain
  input  wire logic              PORT_B_CLOCK_IN,
  // port A control and data
  input  wire logic              PORT_A_CHIP_SEL_N_IN,
  input  wire logic              PORT_A_WRITE_NOT_READ_IN,
  input  wire logic              PORT_A_STROBE_GATE_IN,
  input  wire logic              PORT_A_MAILBOX_PICK_IN,
  input  wire logic [35:0]       PORT_A_DATA_IN,
  output logic      [35:0]       PORT_A_DATA_OUT,
  output logic                   PORT_A_DATA_OE_OUT,
  // port B control and data
  input  wire logic              PORT_B_CHIP_SEL_N_IN,
  input  wire logic              PORT_B_WRITE_NOT_READ_IN,
  input  wire logic              PORT_B_STROBE_GATE_IN,
  input  wire logic              PORT_B_MAILBOX_PICK_IN,
  input  wire logic [35:0]       PORT_B_DATA_IN,
  output logic      [35:0]       PORT_B_DATA_OUT,
  output logic                   PORT_B_DATA_OE_OUT,
  // static configuration and reset pins
  input  wire logic              WIDTH_MATCH_SELECT_IN,
  input  wire logic              PORT_B_SIZE_IN,
  input  wire logic              BYTE_ORDER_PICK_IN,
  input  wire logic              FALL_THROUGH_MODE_IN,
  input  wire logic              FULL_RESET_ONE_N_IN,
  input  wire logic              FULL_RESET_TWO_N_IN,
  input  wire logic              FLUSH_RESET_N_IN,
  input  wire logic              REPLAY_PULSE_N_IN,
  // flags
  output logic                   SPACE_AVAIL_FLAG_OUT,
  output logic                   A_TO_B_MAIL_FLAG_N_OUT,
  output logic                   B_TO_A_MAIL_FLAG_N_OUT
);

  typedef struct packed {
    logic [`A_SYNC_N-1:0] s1;
    logic [`A_SYNC_N-1:0] s2;
    size_t                size;
    logic                 mrs_prev;
    logic [`PTR_W-1:0]    wr_bin;
    logic [`PTR_W-1:0]    wr_gray;
    logic [`PTR_W-1:0]    rd_gray_s1;
    logic [`PTR_W-1:0]    rd_gray_s2;
    logic [35:0]          a_to_b_mailbox;
    logic                 ab_wtog;
    logic                 ab_rtog_s1;
    logic                 ab_rtog_s2;
    logic                 ba_wtog_s1;
    logic                 ba_wtog_s2;
    logic                 ba_cap;
    logic [35:0]          ba_copy;
    logic                 ba_rtog;
    logic [35:0]          dout;
    logic                 oe;
    logic                 space;
    logic                 ab_flag_n;
  } a_state_t;

  typedef struct packed {
    logic [1:0]           rst_sync;
    logic [`B_SYNC_N-1:0] s1;
    logic [`B_SYNC_N-1:0] s2;
    size_t                size;
    logic                 big;
    logic                 mrs_prev;
    logic                 replay_prev;
    logic [`PTR_W-1:0]    rd_bin;
    logic [`PTR_W-1:0]    rd_gray;
    logic [`PTR_W-1:0]    wr_gray_s1;
    logic [`PTR_W-1:0]    wr_gray_s2;
    phase_t               phase;
    logic [35:0]          aux;
    logic [35:0]          fifo_out;
    logic [35:0]          b_to_a_mailbox;
    logic                 ba_wtog;
    logic                 ba_rtog_s1;
    logic                 ba_rtog_s2;
    logic                 ab_wtog_s1;
    logic                 ab_wtog_s2;
    logic                 ab_cap;
    logic [35:0]          ab_copy;
    logic                 ab_rtog;
    logic [35:0]          dout;
    logic                 oe;
    logic                 ba_flag_n;
  } b_state_t;

  a_state_t          a;
  a_state_t          next_a;
  b_state_t          b;
  b_state_t          next_b;
  logic [35:0]       mem [`DEPTH];
  logic              mem_we;
  logic [35:0]       mem_rd;

  // unused upper lanes read as 0 instead of floating
  function automatic logic [35:0] lane_mask(input size_t s);
    case (s)
      SZ_WORD: lane_mask = `MASK_WORD;
      SZ_BYTE: lane_mask = `MASK_BYTE;
      default: lane_mask = `MASK_LONG;
    endcase
  endfunction

  // match low forces long-word reads whatever the size pin says
  function automatic size_t decode_size(input logic match, input logic sz);
    if (!match)
      decode_size = SZ_LONG;
    else if (sz)
      decode_size = SZ_BYTE;
    else
      decode_size = SZ_WORD;
  endfunction

  function automatic logic [`PTR_W-1:0] gray2bin(
    input logic [`PTR_W-1:0] g);
    logic [`PTR_W-1:0] r;
    r = g;
    for (int i = `PTR_W-2; i >= 0; i--) begin
      r[i] = r[i+1] ^ g[i];
    end
    gray2bin = r;
  endfunction

  // part k of a long-word, placed in the low lanes
  function automatic logic [35:0] part(input logic [35:0] w,
                                       input size_t s,
                                       input logic be,
                                       input logic [1:0] k);
    logic [1:0] idx;
    idx = be ? 2'(2'h3 - k) : k;                     // [R24]
    case (s)
      SZ_WORD: part = {18'h00000, (be ^ k[0]) ? w[35:18] : w[17:0]};
      SZ_BYTE: part = {27'h0000000, w[9*idx +: `BYTE_W]};  // [R17]
      default: part = w;
    endcase
  endfunction

  // port A domain
  logic a_mrs_n;
  logic a_rst_n;
  logic a_wsel;
  logic [`PTR_W-1:0] a_rd_bin;

  always_comb begin
    next_a = a;
    next_a.s1 = {FLUSH_RESET_N_IN ? 1'b1 : 1'b0, 5'h00};
    next_a.s1[`SY_RST_ONE] = FULL_RESET_ONE_N_IN;
    next_a.s1[`SY_RST_TWO] = FULL_RESET_TWO_N_IN;
    next_a.s1[`SY_FLUSH] = FLUSH_RESET_N_IN;
    next_a.s1[`SY_MATCH] = WIDTH_MATCH_SELECT_IN;
    next_a.s1[`SY_SIZE] = PORT_B_SIZE_IN;
    next_a.s1[`SY_ORDER] = BYTE_ORDER_PICK_IN;
    next_a.s2 = a.s1;
    a_mrs_n = a.s2[`SY_RST_ONE] & a.s2[`SY_RST_TWO];
    a_rst_n = a_mrs_n & a.s2[`SY_FLUSH];
    next_a.mrs_prev = a_mrs_n;
    if (a_mrs_n && !a.mrs_prev) begin
      next_a.size = decode_size(a.s2[`SY_MATCH], a.s2[`SY_SIZE]); // [R12]
    end
    // read count arrives as registered gray through two flops
    next_a.rd_gray_s1 = b.rd_gray;
    next_a.rd_gray_s2 = a.rd_gray_s1;
    // lone toggles cross; the words they guard are steady by then
    next_a.ab_rtog_s1 = b.ab_rtog;
    next_a.ab_rtog_s2 = a.ab_rtog_s1;
    next_a.ba_wtog_s1 = b.ba_wtog;
    next_a.ba_wtog_s2 = a.ba_wtog_s1;
    a_wsel = !PORT_A_CHIP_SEL_N_IN && PORT_A_WRITE_NOT_READ_IN
             && PORT_A_STROBE_GATE_IN;
    // queue only ever sees whole long-words
    mem_we = a_wsel && !PORT_A_MAILBOX_PICK_IN && a.space;  // [R14] [R22]
    if (!a_rst_n) begin
      next_a.wr_bin = '0;
    end else if (mem_we) begin
      next_a.wr_bin = a.wr_bin + 1'b1;
    end
    next_a.wr_gray = next_a.wr_bin ^ (next_a.wr_bin >> 1);
    a_rd_bin = gray2bin(a.rd_gray_s2);
    next_a.space = a_rst_n
                   && (next_a.wr_bin - a_rd_bin) != `PTR_W'(`DEPTH); // [R22]
    // mailbox write accepted only while the flag is high
    if (a_wsel && PORT_A_MAILBOX_PICK_IN && a.ab_flag_n) begin  // [R3] [R7]
      next_a.a_to_b_mailbox = PORT_A_DATA_IN & lane_mask(a.size); // [R4] [R15]
      next_a.ab_wtog = ~a.ab_wtog;                   // [R1]
    end
    next_a.ab_flag_n = (next_a.ab_wtog == a.ab_rtog_s2);  // [R7] [R8]
    // copy taken once the toggle settles; source is stable by then
    if (a.ba_wtog_s2 != a.ba_cap) begin
      next_a.ba_copy = b.b_to_a_mailbox;
      next_a.ba_cap = a.ba_wtog_s2;
    end
    if (!PORT_A_CHIP_SEL_N_IN && !PORT_A_WRITE_NOT_READ_IN
        && PORT_A_STROBE_GATE_IN && PORT_A_MAILBOX_PICK_IN
        && a.ba_cap != a.ba_rtog) begin
      next_a.ba_rtog = ~a.ba_rtog;                   // [R9] [R10]
    end
    next_a.oe = !PORT_A_CHIP_SEL_N_IN && !PORT_A_WRITE_NOT_READ_IN;
    // port A has no fifo output, so it always shows the mailbox
    next_a.dout = next_a.ba_copy & lane_mask(a.size);  // [R2] [R11]
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      a <= '{size: SZ_LONG, ab_flag_n: 1'b1, default: '0};
    end else begin
      a <= next_a;
    end
  end

  // dual-port storage, written only from port A
  always_ff @(posedge CLOCK_IN) begin
    if (mem_we) begin
      mem[a.wr_bin[`ADDR_W-1:0]] <= PORT_A_DATA_IN;
    end
  end

  assign mem_rd = mem[b.rd_bin[`ADDR_W-1:0]];

  // port B domain
  logic b_mrs_n;
  logic b_rst_n;
  logic b_rsel;
  logic b_empty;
  logic b_last;
  logic [1:0] b_k;

  always_comb begin
    next_b = b;
    // port B leaves reset two of its own edges after the pin rises
    next_b.rst_sync = {b.rst_sync[0], 1'b1};
    next_b.s1 = '0;
    next_b.s1[`SY_RST_ONE] = FULL_RESET_ONE_N_IN;
    next_b.s1[`SY_RST_TWO] = FULL_RESET_TWO_N_IN;
    next_b.s1[`SY_FLUSH] = FLUSH_RESET_N_IN;
    next_b.s1[`SY_MATCH] = WIDTH_MATCH_SELECT_IN;
    next_b.s1[`SY_SIZE] = PORT_B_SIZE_IN;
    next_b.s1[`SY_ORDER] = BYTE_ORDER_PICK_IN;
    next_b.s1[`SY_REPLAY] = REPLAY_PULSE_N_IN;
    next_b.s1[`SY_FALL_THROUGH_MODE] = FALL_THROUGH_MODE_IN;
    next_b.s2 = b.s1;
    b_mrs_n = b.s2[`SY_RST_ONE] & b.s2[`SY_RST_TWO];
    b_rst_n = b_mrs_n & b.s2[`SY_FLUSH];
    next_b.mrs_prev = b_mrs_n;
    if (b_mrs_n && !b.mrs_prev) begin
      next_b.size = decode_size(b.s2[`SY_MATCH], b.s2[`SY_SIZE]); // [R12]
      next_b.big = b.s2[`SY_ORDER];                  // [R13]
    end
    // replay acts on the synchronised falling edge of the pulse
    next_b.replay_prev = b.s2[`SY_REPLAY];
    next_b.wr_gray_s1 = a.wr_gray;
    next_b.wr_gray_s2 = b.wr_gray_s1;
    next_b.ba_rtog_s1 = a.ba_rtog;
    next_b.ba_rtog_s2 = b.ba_rtog_s1;
    next_b.ab_wtog_s1 = a.ab_wtog;
    next_b.ab_wtog_s2 = b.ab_wtog_s1;
    b_empty = b.rd_gray == b.wr_gray_s2;
    b_rsel = !PORT_B_CHIP_SEL_N_IN && PORT_B_WRITE_NOT_READ_IN
             && PORT_B_STROBE_GATE_IN;
    case (b.phase)
      PH1:     b_k = 2'h1;
      PH2:     b_k = 2'h2;
      PH3:     b_k = 2'h3;
      default: b_k = 2'h0;
    endcase
    b_last = (b.size == SZ_WORD && b.phase == PH1) || b.phase == PH3;
    if (!b_rst_n) begin
      next_b.rd_bin = '0;
      next_b.phase = PH0;
    end else if (!b.s2[`SY_REPLAY] && b.replay_prev
                 && !b.s2[`SY_FALL_THROUGH_MODE]) begin
      // rewind only; strobe is held off by the host meanwhile
      next_b.rd_bin = '0;                            // [R18] [R19] [R20]
      next_b.phase = PH0;
    end else if (b_rsel && !PORT_B_MAILBOX_PICK_IN) begin  // [R23]
      case (b.phase)
        PH0: begin
          // empty only gates the first part; the rest wait in aux
          if (!b_empty) begin                        // [R21]
            next_b.rd_bin = b.rd_bin + 1'b1;
            next_b.aux = mem_rd;                     // [R16]
            next_b.fifo_out = part(mem_rd, b.size, b.big, 2'h0);
            if (b.size != SZ_LONG) begin
              next_b.phase = PH1;
            end
          end
        end
        PH1, PH2, PH3: begin
          next_b.fifo_out = part(b.aux, b.size, b.big, b_k); // [R16] [R24]
          next_b.phase = b_last ? PH0 : phase_t'(b.phase << 1);
        end
        default: next_b.phase = PH0;
      endcase
    end
    // registered gray copy, so port A never samples a half-changed count
    next_b.rd_gray = next_b.rd_bin ^ (next_b.rd_bin >> 1);
    if (!PORT_B_CHIP_SEL_N_IN && !PORT_B_WRITE_NOT_READ_IN
        && PORT_B_STROBE_GATE_IN && PORT_B_MAILBOX_PICK_IN
        && b.ba_flag_n) begin                        // [R5] [R7]
      next_b.b_to_a_mailbox = PORT_B_DATA_IN & lane_mask(b.size); // [R6]
      next_b.ba_wtog = ~b.ba_wtog;                   // [R1]
    end
    next_b.ba_flag_n = (next_b.ba_wtog == b.ba_rtog_s2);  // [R7] [R9]
    if (b.ab_wtog_s2 != b.ab_cap) begin
      next_b.ab_copy = a.a_to_b_mailbox;
      next_b.ab_cap = b.ab_wtog_s2;
    end
    if (b_rsel && PORT_B_MAILBOX_PICK_IN && b.ab_cap != b.ab_rtog) begin
      next_b.ab_rtog = ~b.ab_rtog;                   // [R8] [R10]
    end
    next_b.oe = !PORT_B_CHIP_SEL_N_IN && PORT_B_WRITE_NOT_READ_IN;
    // mailbox bypasses the matcher, just trimmed to the lanes in use
    next_b.dout = PORT_B_MAILBOX_PICK_IN
                  ? (next_b.ab_copy & lane_mask(b.size))  // [R2] [R11] [R15]
                  : next_b.fifo_out;                 // [R2]
  end

  always_ff @(posedge PORT_B_CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      b <= '{size: SZ_LONG, phase: PH0, ba_flag_n: 1'b1, default: '0};
    end else if (!b.rst_sync[1]) begin
      b <= '{size: SZ_LONG, phase: PH0, ba_flag_n: 1'b1,
             rst_sync: next_b.rst_sync, default: '0};
    end else begin
      b <= next_b;
    end
  end

  // outputs come straight off register fields
  assign PORT_A_DATA_OUT        = a.dout;
  assign PORT_A_DATA_OE_OUT     = a.oe;
  assign SPACE_AVAIL_FLAG_OUT   = a.space;
  assign A_TO_B_MAIL_FLAG_N_OUT = a.ab_flag_n;
  assign PORT_B_DATA_OUT        = b.dout;
  assign PORT_B_DATA_OE_OUT     = b.oe;
  assign B_TO_A_MAIL_FLAG_N_OUT = b.ba_flag_n;

endmodule

//--- design/fifo_mb_pkg.sv
// types for the mailbox / bus-matching fifo
package fifo_mb_pkg;
  typedef enum logic [2:0] {
    SZ_LONG = 3'b001,
    SZ_WORD = 3'b010,
    SZ_BYTE = 3'b100
  } size_t;
  typedef enum logic [3:0] {
    PH0 = 4'b0001,
    PH1 = 4'b0010,
    PH2 = 4'b0100,
    PH3 = 4'b1000
  } phase_t;
endpackage

//--- design/fifo_mb_regs.svh
// constants and operation summary for the mailbox / bus-matching fifo
// Operation
// [R1] two 36-bit mailboxes, A-to-B and B-to-A, bypassing the queue
// [R2] port data out shows mailbox when its pick is high, else fifo register
// [R3] port A write with port_a_mailbox_pick high loads the A-to-B mailbox
// [R4] A-to-B mailbox keeps A lines 0-35, 0-17 or 0-8 by bus size
// [R5] port B write with port_b_mailbox_pick high loads the B-to-A mailbox
// [R6] B-to-A mailbox keeps B lines 0-35, 0-17 or 0-8 by bus size
// [R7] mailbox write drops its full flag low; writes ignored while low
// [R8] port B mailbox read raises the A-to-B flag
// [R9] port A mailbox read raises the B-to-A flag
// [R10] reading a mailbox never changes its contents
// [R11] mailbox data gets no endian reorder or splitting
// [R12] size and match select pick 36/18/9-bit reads, applied at reset end
// [R13] byte order latched on full reset rising edge; ignored in long mode
// [R14] memory holds whole 36-bit long-words; matching happens after read
// [R15] word/byte size: mailbox uses lanes 0-17 or 0-8 only
// [R16] long mode reads whole word; narrower modes hold rest in aux register
// [R17] narrow fifo reads leave port B bits above 17 or 8 unused
// [R18] standard mode low replay pulse rewinds read pointer to location 0
// [R19] host keeps port B strobe off during replay and recovery time
// [R20] host writes fewer than depth minus 2/4/8 words before replay
// [R21] after replay reads resend data until pointers meet; flags follow
// [R22] space flag high means room; fifo writes ignored when low
// [R23] fifo read: chip select low, read, strobe high, mailbox pick low
// [R24] little endian gives low part first, big endian high part first
`ifndef FIFO_MB_REGS_SVH
`define FIFO_MB_REGS_SVH
`define DATA_W      36
`define HALF_W      18
`define BYTE_W      9
`define DEPTH       1024
`define ADDR_W      10
`define PTR_W       11
`define A_SYNC_N    6
`define B_SYNC_N    8
`define SY_RST_ONE  0
`define SY_RST_TWO  1
`define SY_FLUSH    2
`define SY_MATCH    3
`define SY_SIZE     4
`define SY_ORDER    5
`define SY_REPLAY   6
`define SY_FALL_THROUGH_MODE     7
`define MASK_LONG   36'hFFFFFFFFF
`define MASK_WORD   36'h00003FFFF
`define MASK_BYTE   36'h0000001FF
`endif

//--- sim/fifo_mb_asserts.sv
// port-level assertions for the mailbox / bus-matching fifo
`timescale 1ns/1ns
module fifo_mb_asserts (
  // clocks and resets
  input wire logic        CLOCK_IN, RST_N_IN, PORT_B_CLOCK_IN,
  input wire logic        FULL_RESET_ONE_N_IN,
  // port A
  input wire logic        PORT_A_CHIP_SEL_N_IN, PORT_A_WRITE_NOT_READ_IN,
  input wire logic        PORT_A_STROBE_GATE_IN, PORT_A_MAILBOX_PICK_IN,
  input wire logic [35:0] PORT_A_DATA_OUT,
  input wire logic        PORT_A_DATA_OE_OUT,
  // port B
  input wire logic        PORT_B_CHIP_SEL_N_IN, PORT_B_WRITE_NOT_READ_IN,
  input wire logic        PORT_B_STROBE_GATE_IN, PORT_B_MAILBOX_PICK_IN,
  input wire logic [35:0] PORT_B_DATA_OUT,
  input wire logic        PORT_B_DATA_OE_OUT,
  // flags
  input wire logic        SPACE_AVAIL_FLAG_OUT, A_TO_B_MAIL_FLAG_N_OUT,
  input wire logic        B_TO_A_MAIL_FLAG_N_OUT
);
  wire a_wr_mb = !PORT_A_CHIP_SEL_N_IN && PORT_A_WRITE_NOT_READ_IN &&
                 PORT_A_STROBE_GATE_IN && PORT_A_MAILBOX_PICK_IN;
  wire b_wr_mb = !PORT_B_CHIP_SEL_N_IN && !PORT_B_WRITE_NOT_READ_IN &&
                 PORT_B_STROBE_GATE_IN && PORT_B_MAILBOX_PICK_IN;
  wire b_rd    = !PORT_B_CHIP_SEL_N_IN && PORT_B_WRITE_NOT_READ_IN &&
                 PORT_B_STROBE_GATE_IN && !PORT_B_MAILBOX_PICK_IN;
  // full reset may clear the output register late, so hold off after it
  logic [7:0] quiet;
  always_ff @(posedge PORT_B_CLOCK_IN or negedge RST_N_IN)
    if (!RST_N_IN) quiet <= 8'h0;
    else if (!FULL_RESET_ONE_N_IN) quiet <= 8'h0;
    else if (quiet != 8'hFF) quiet <= quiet + 8'h1;
  a_ab_fill: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_N_IN) a_wr_mb && A_TO_B_MAIL_FLAG_N_OUT
    |=> !A_TO_B_MAIL_FLAG_N_OUT) else $error("a to b flag not set");
  a_ba_fill: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RST_N_IN) b_wr_mb && B_TO_A_MAIL_FLAG_N_OUT
    |=> !B_TO_A_MAIL_FLAG_N_OUT) else $error("b to a flag not set");
  a_ab_cause: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_N_IN) $fell(A_TO_B_MAIL_FLAG_N_OUT) |-> $past(a_wr_mb))
    else $error("a to b flag fell without write");
  a_ba_cause: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RST_N_IN) $fell(B_TO_A_MAIL_FLAG_N_OUT) |-> $past(b_wr_mb))
    else $error("b to a flag fell without write");
  a_a_drive: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    PORT_A_DATA_OE_OUT == $past(!PORT_A_CHIP_SEL_N_IN &&
    !PORT_A_WRITE_NOT_READ_IN)) else $error("port a enable wrong");
  a_b_drive: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RST_N_IN) PORT_B_DATA_OE_OUT == $past(!PORT_B_CHIP_SEL_N_IN
    && PORT_B_WRITE_NOT_READ_IN)) else $error("port b enable wrong");
  a_fifo_hold: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RST_N_IN) !PORT_B_STROBE_GATE_IN && !PORT_B_MAILBOX_PICK_IN
    && $past(!PORT_B_MAILBOX_PICK_IN) && quiet == 8'hFF
    |=> $stable(PORT_B_DATA_OUT)) else $error("port b output moved idle");
  a_mail_intact: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_N_IN) FULL_RESET_ONE_N_IN && $past(FULL_RESET_ONE_N_IN, 8)
    && $changed(PORT_A_DATA_OUT) |-> !B_TO_A_MAIL_FLAG_N_OUT)
    else $error("b to a mailbox changed without write");
  c_ab_write: cover property (@(posedge CLOCK_IN) a_wr_mb);
  c_full: cover property (@(posedge CLOCK_IN) $fell(SPACE_AVAIL_FLAG_OUT));
  c_b_read: cover property (@(posedge PORT_B_CLOCK_IN) b_rd);
endmodule
bind fifo_mb fifo_mb_asserts chk (.*);

//--- sim/port_b_host.sv
// port B host model: one mailbox or fifo cycle at a time
`timescale 1ns/1ns
module port_b_host (
  // clock and read data
  input  wire logic        clk_in,
  input  wire logic [35:0] rd_in,
  // controls and write data
  output logic             cs_n_out,
  output logic             wnr_out,
  output logic             strobe_out,
  output logic             pick_out,
  output logic [35:0]      wd_out
);
  initial begin
    cs_n_out = 1'h1;
    wnr_out = 1'h1;
    strobe_out = 1'h0;
    pick_out = 1'h0;
    wd_out = 36'h0;
  end
  // strobe is low between cycles, so a replay never sees it
  task automatic op(input logic w, input logic m, input logic [35:0] d,
                    output logic [35:0] q);
    @(posedge clk_in);
    #1;
    cs_n_out = 1'h0;
    wnr_out = !w;
    strobe_out = 1'h1;
    pick_out = m;
    wd_out = d;
    @(posedge clk_in);
    #1;
    q = rd_in;
    strobe_out = 1'h0;
    cs_n_out = 1'h1;
    wd_out = ~d; // released lines must not keep the last value
  endtask
endmodule

//--- sim/test_fifo_mb.sv
// self-checking bench for the mailbox / bus-matching fifo
`timescale 1ns/1ns
module test_fifo_mb;
  logic        clk = 1'h0;
  logic        bclk = 1'h0;
  logic        rst_n = 1'h0;
  logic        a_cs_n = 1'h1;
  logic        a_wnr = 1'h0;
  logic        a_stb = 1'h0;
  logic        a_pick = 1'h0;
  logic [35:0] a_din = 36'h0;
  logic        bm = 1'h0;
  logic        sz = 1'h0;
  logic        be = 1'h0;
  logic        frst_n = 1'h1;
  logic        replay_n = 1'h1;
  logic        fall_through_mode = 1'h0;
  logic        flush_n = 1'h1;
  wire  [35:0] a_dout, b_dout, b_din;
  wire         a_oe, b_oe, b_cs_n, b_wnr, b_stb, b_pick, space, ab_n, ba_n;
  int          mismatches = 0;
  int          checks = 0;
  int          seed = 32'h53B40102;
  int          n = 1;
  logic [35:0] q, d;
  logic [35:0] words [$];
  logic [2:0]  cfgs [5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  fifo_mb uut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .PORT_B_CLOCK_IN(bclk),
    .PORT_A_CHIP_SEL_N_IN(a_cs_n), .PORT_A_WRITE_NOT_READ_IN(a_wnr),
    .PORT_A_STROBE_GATE_IN(a_stb), .PORT_A_MAILBOX_PICK_IN(a_pick),
    .PORT_A_DATA_IN(a_din), .PORT_A_DATA_OUT(a_dout),
    .PORT_A_DATA_OE_OUT(a_oe), .PORT_B_CHIP_SEL_N_IN(b_cs_n),
    .PORT_B_WRITE_NOT_READ_IN(b_wnr), .PORT_B_STROBE_GATE_IN(b_stb),
    .PORT_B_MAILBOX_PICK_IN(b_pick), .PORT_B_DATA_IN(b_din),
    .PORT_B_DATA_OUT(b_dout), .PORT_B_DATA_OE_OUT(b_oe),
    .WIDTH_MATCH_SELECT_IN(bm), .PORT_B_SIZE_IN(sz),
    .BYTE_ORDER_PICK_IN(be), .FALL_THROUGH_MODE_IN(fall_through_mode),
    .FULL_RESET_ONE_N_IN(frst_n), .FULL_RESET_TWO_N_IN(frst_n),
    .FLUSH_RESET_N_IN(flush_n), .REPLAY_PULSE_N_IN(replay_n),
    .SPACE_AVAIL_FLAG_OUT(space), .A_TO_B_MAIL_FLAG_N_OUT(ab_n),
    .B_TO_A_MAIL_FLAG_N_OUT(ba_n)
  );
  port_b_host host (
    .clk_in(bclk), .rd_in(b_dout), .cs_n_out(b_cs_n), .wnr_out(b_wnr),
    .strobe_out(b_stb), .pick_out(b_pick), .wd_out(b_din)
  );
  initial forever #50 clk = ~clk;
  initial begin
    #1;
    forever #3 bclk = ~bclk;
  end
  function automatic logic [35:0] msk();
    return (36'h1 << (36 / n)) - 36'h1;
  endfunction
  // k-th part of a long-word as port B shows it
  function automatic logic [35:0] part(logic [35:0] wd, int k);
    int i;
    i = be ? n - 1 - k : k;
    return (wd >> (i * (36 / n))) & msk();
  endfunction
  task automatic chk(input logic [35:0] seen, input logic [35:0] want,
                     input string what);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic a_op(input logic w, input logic m, input logic [35:0] dd);
    @(posedge clk);
    #1;
    a_cs_n = 1'h0;
    a_wnr = w;
    a_stb = 1'h1;
    a_pick = m;
    a_din = dd;
    @(posedge clk);
    #1;
    q = a_dout;
    a_stb = 1'h0;
    a_cs_n = 1'h1;
    a_din = ~dd;
  endtask
  task automatic wait_a(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic rd_all();
    foreach (words[i])
      for (int k = 0; k < n; k++) begin
        host.op(1'h0, 1'h0, 36'h0, q);
        chk(q, part(words[i], k), "fifo part");
      end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
  initial begin
    wait_a(12);
    rst_n = 1'h1;
    for (int m = 0; m < 5; m++) begin
      {bm, sz, be} = cfgs[m];
      n = !bm ? 1 : (sz ? 4 : 2);
      frst_n = 1'h0;
      wait_a(10);
      frst_n = 1'h1;
      wait_a(6);
      chk({35'h0, space}, 36'h1, "space flag");
      d = 36'({$random(seed), $random(seed)});
      a_op(1'h1, 1'h1, d);
      chk({35'h0, ab_n}, 36'h0, "ab flag low");
      a_op(1'h1, 1'h1, ~d);
      wait_a(4);
      host.op(1'h0, 1'h1, d, q);
      chk(q, d & msk(), "ab mailbox");
      wait_a(4);
      chk({35'h0, ab_n}, 36'h1, "ab flag high");
      host.op(1'h0, 1'h1, ~d, q);
      chk(q, d & msk(), "ab reread");
      host.op(1'h1, 1'h1, ~d, q);
      chk({35'h0, ba_n}, 36'h0, "ba flag low");
      host.op(1'h1, 1'h1, d, q);
      wait_a(4);
      a_op(1'h0, 1'h1, d);
      chk(q, ~d & msk(), "ba mailbox");
      wait_a(4);
      chk({35'h0, ba_n}, 36'h1, "ba flag high");
      words.delete();
      repeat (3) begin // well under depth before replay
        d = 36'({$random(seed), $random(seed)});
        words.push_back(d);
        a_op(1'h1, 1'h0, d);
      end
      wait_a(2);
      rd_all();
      host.op(1'h0, 1'h0, 36'h0, d);
      chk(d, q, "empty read held");
      replay_n = 1'h0;
      wait_a(3);
      replay_n = 1'h1;
      wait_a(2);
      rd_all();
      d = 36'({$random(seed), $random(seed)});
      words = '{d};
      a_op(1'h1, 1'h0, d);
      wait_a(2);
      rd_all();
      fall_through_mode = 1'h1;
      replay_n = 1'h0;
      wait_a(3);
      replay_n = 1'h1;
      wait_a(2);
      fall_through_mode = 1'h0;
      host.op(1'h0, 1'h0, 36'h0, d);
      chk(d, q, "no replay in fall_through_mode");
      $display("test %0d done", m);
    end
    // a word left unread must vanish with the flush
    a_op(1'h1, 1'h0, 36'h0);
    flush_n = 1'h0;
    wait_a(4);
    flush_n = 1'h1;
    wait_a(6);
    for (int i = 0; i < 1024; i++) begin
      if (i == 1023)
        chk({35'h0, space}, 36'h1, "room left");
      a_op(1'h1, 1'h0, 36'(i) + 36'h100);
    end
    chk({35'h0, space}, 36'h0, "fifo full");
    a_op(1'h1, 1'h0, 36'hFFFFFFFFF);
    words = '{36'h100};
    rd_all();
    $display("test fill done");
    stop_test();
  end
endmodule
